// file: rtl/acp_pwm_seq.sv
// Sequencer core of a peak current-mode active-clamp PWM controller.
// Assumes analog comparators deliver asynchronous digital levels; rst is the
// supply_low_lockout release.
`timescale 1ns/1ps
module acp_pwm_seq
  import acp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic lineUnderSense,
  input wire logic lineOverSense,
  input wire logic refGood,
  input wire logic csLimit,
  input wire logic fbAboveZero,
  input wire logic ssAboveLow,
  input wire logic ssAboveCtl,
  input wire logic syncIn,
  input wire logic [CNT_W-1:0] pwmCmp,
  input wire logic [CNT_W-1:0] clampStep,
  output logic mainGate,
  output logic clampGate,
  output logic ssCharge,
  output logic ssDischarge,
  output logic rampCharging
);
  acp_sync_if syncBus ();
  acp_in_sync u_sync (
    .clk(clk),
    .rst(rst),
    .rawIn({syncIn, ssAboveCtl, ssAboveLow, fbAboveZero, csLimit, refGood,
            lineOverSense, lineUnderSense}),
    .syncOut(syncBus.src)
  );

  wire logic line_under_sense = syncBus.lvl[0];
  wire logic line_over_sense = syncBus.lvl[1];
  wire logic refOk = syncBus.lvl[2];
  wire logic csHi = syncBus.lvl[3];
  wire logic fbOk = syncBus.lvl[4];
  wire logic ssLow = ~syncBus.lvl[5];
  wire logic ssInBand = syncBus.lvl[6];
  wire logic syncLvl = syncBus.lvl[7];

  acp_state_e state_ff;
  acp_state_e nxt_state;
  logic charging_ff;
  logic [CNT_W-1:0] rampCnt_ff;
  logic syncPrev_ff;
  logic [CNT_W-1:0] stuckCnt_ff;
  logic skip_ff;
  logic [CNT_W-1:0] uvClampExt_ff;
  logic mainGate_ff;
  logic clampGate_ff;
  logic ssCharge_ff;
  logic ssDischarge_ff;

  localparam logic [CNT_W-1:0] CHG_END = CNT_W'(CHG_CYC - 1);
  localparam logic [CNT_W-1:0] DIS_END = CNT_W'(DIS_CYC - 1);
  localparam logic [CNT_W-1:0] STUCK_END = CNT_W'(SYNC_STUCK_CYC);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  // Oscillator: sync edge only shortens the charge; counts fixed in both modes
  wire logic syncRise = syncLvl & ~syncPrev_ff;
  wire logic syncStuck = (stuckCnt_ff == STUCK_END);
  wire logic chargeDone = charging_ff & ((rampCnt_ff == CHG_END) | syncRise);
  // High sync holds the ramp flat at its valley, as an over-wide pulse does
  wire logic valleyHit = ~charging_ff & (rampCnt_ff == DIS_END) & ~syncLvl;
  wire logic [CNT_W-1:0] nxt_ramp = (chargeDone | valleyHit) ? {CNT_W{1'b0}}
                                   : (~charging_ff & (rampCnt_ff == DIS_END)) ? rampCnt_ff
                                   : rampCnt_ff + CNT_ONE;
  wire logic nxt_charging = chargeDone ? 1'b0 : (valleyHit ? 1'b1 : charging_ff);
  wire logic [CNT_W-1:0] nxt_stuck = ~syncLvl ? {CNT_W{1'b0}}
                                    : (syncStuck ? stuckCnt_ff : stuckCnt_ff + CNT_ONE);

  wire logic lineOk = ~line_under_sense & ~line_over_sense;
  wire logic permit = refOk & ~csHi & fbOk & lineOk;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ACP_OFF: if (line_over_sense) nxt_state = ACP_OVDIS;
               else if (refOk & lineOk) nxt_state = ACP_RUN;
      ACP_RUN: if (line_over_sense) nxt_state = ACP_OVDIS;
               else if (line_under_sense) nxt_state = ACP_UVDIS;
      ACP_UVDIS: if (line_over_sense) nxt_state = ACP_OVDIS;
                 else if (ssLow & ~line_under_sense) nxt_state = ACP_RUN;
      ACP_OVDIS: if (ssLow & ~line_over_sense) nxt_state = ACP_OFF;
      default: nxt_state = ACP_OFF;
    endcase
  end

  // Zero duty demand latched at cycle start skips main and clamp together
  wire logic cycleStart = valleyHit;
  wire logic uvDis = (state_ff == ACP_UVDIS);
  // Undervoltage itself must not skip cycles, or the clamp charge would stay stranded
  wire logic dutyOk = refOk & ~csHi & fbOk & ~line_over_sense & (~line_under_sense | uvDis) & ssInBand;
  wire logic nxt_skip = cycleStart ? ~dutyOk : skip_ff;
  wire logic running = (state_ff == ACP_RUN) & ~syncStuck;
  wire logic mainOn = running & charging_ff & ~skip_ff & permit & ssInBand
                      & (rampCnt_ff < pwmCmp);
  // Clamp widens by clampStep each cycle during undervoltage discharge, until the next step would pass CHG_END, by eating into the
  // former main slot, so clamp voltage is never held long across the core
  wire logic uvClampOn = (state_ff == ACP_UVDIS) & ~syncStuck & ~skip_ff
                         & (~charging_ff | (rampCnt_ff < uvClampExt_ff));
  wire logic clampOn = (running & ~skip_ff & ~mainOn) | uvClampOn;
  wire logic [CNT_W-1:0] nxt_uvExt = (state_ff != ACP_UVDIS) ? {CNT_W{1'b0}}
                                    : (cycleStart & (uvClampExt_ff <= CHG_END - clampStep))
                                      ? uvClampExt_ff + clampStep : uvClampExt_ff;
  wire logic nxt_ssChg = (state_ff == ACP_RUN) | ((state_ff == ACP_OFF) & refOk & lineOk);
  // Main is launched only into a cycle that is still charging, so the registered
  // gate never spills into the first discharge cycle
  wire logic mainNext = mainOn & nxt_charging & ~line_over_sense & ~line_under_sense;
  wire logic nxt_ssDis = (nxt_state == ACP_UVDIS) | (nxt_state == ACP_OVDIS);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ACP_OFF;
      charging_ff <= 1'b1;
      rampCnt_ff <= {CNT_W{1'b0}};
      syncPrev_ff <= 1'b0;
      stuckCnt_ff <= {CNT_W{1'b0}};
      skip_ff <= 1'b1;
      uvClampExt_ff <= {CNT_W{1'b0}};
    end else begin
      state_ff <= nxt_state;
      charging_ff <= nxt_charging;
      rampCnt_ff <= nxt_ramp;
      syncPrev_ff <= syncLvl;
      stuckCnt_ff <= nxt_stuck;
      skip_ff <= nxt_skip;
      uvClampExt_ff <= nxt_uvExt;
    end
  end

  // Overvoltage forces gates low on the very next edge
  always_ff @(posedge clk) begin
    if (rst) begin
      mainGate_ff <= 1'b0;
      clampGate_ff <= 1'b0;
      ssCharge_ff <= 1'b0;
      ssDischarge_ff <= 1'b0;
    end else begin
      mainGate_ff <= mainNext;
      clampGate_ff <= clampOn & ~line_over_sense & ~mainOn;
      ssCharge_ff <= nxt_ssChg;
      ssDischarge_ff <= nxt_ssDis;
    end
  end

  assign mainGate = mainGate_ff;
  assign clampGate = clampGate_ff;
  assign ssCharge = ssCharge_ff;
  assign ssDischarge = ssDischarge_ff;
  assign rampCharging = charging_ff;

  a_main_ramp_off: assert property (@(posedge clk) disable iff (rst)
    !charging_ff |-> !mainGate_ff)
    else $error("main on during ramp reset");
  a_ov_gates_off: assert property (@(posedge clk) disable iff (rst)
    line_over_sense |=> !mainGate_ff && !clampGate_ff)
    else $error("gate on during overvoltage");
  a_ov_hold_off: assert property (@(posedge clk) disable iff (rst)
    state_ff == ACP_OVDIS |=> !mainGate_ff && !clampGate_ff)
    else $error("gate on in ov");
  a_uv_main_off: assert property (@(posedge clk) disable iff (rst)
    state_ff == ACP_UVDIS |=> !mainGate_ff)
    else $error("main on during uv");
  a_gates_exclusive: assert property (@(posedge clk) disable iff (rst)
    !(mainGate_ff && clampGate_ff))
    else $error("main and clamp both on");
  a_skip_both: assert property (@(posedge clk) disable iff (rst)
    skip_ff |=> !mainGate_ff && !clampGate_ff)
    else $error("skip not on both");
  a_stuck_off: assert property (@(posedge clk) disable iff (rst)
    syncStuck |=> !mainGate_ff && !clampGate_ff)
    else $error("sync stuck gates on");
  a_charge_len: assert property (@(posedge clk) disable iff (rst)
    charging_ff |-> rampCnt_ff <= CHG_END)
    else $error("charge exceeds count");
  a_sync_end: assert property (@(posedge clk) disable iff (rst)
    charging_ff && syncRise |=> !charging_ff)
    else $error("sync edge ignored");
  a_ov_ss_dis: assert property (@(posedge clk) disable iff (rst)
    state_ff == ACP_RUN && line_over_sense |=> ssDischarge_ff)
    else $error("no ss discharge");
  a_permit_main: assert property (@(posedge clk) disable iff (rst)
    !permit |=> !mainGate_ff)
    else $error("main on without permit");
  a_band_main: assert property (@(posedge clk) disable iff (rst)
    !ssInBand |=> !mainGate_ff)
    else $error("main on outside soft-start band");
  a_uv_clamp_on: assert property (@(posedge clk) disable iff (rst)
    uvDis && !charging_ff && !skip_ff && !syncStuck && !line_over_sense |=> clampGate_ff)
    else $error("clamp idle during uv discharge");
  a_uv_ss_dis: assert property (@(posedge clk) disable iff (rst)
    uvDis |-> ssDischarge_ff)
    else $error("no ss discharge in uv");
  a_ov_wait: assert property (@(posedge clk) disable iff (rst)
    state_ff == ACP_OVDIS && (line_over_sense || !ssLow) |=> state_ff == ACP_OVDIS)
    else $error("ov left too early");
  a_valley_start: assert property (@(posedge clk) disable iff (rst)
    !charging_ff && rampCnt_ff == DIS_END && !syncLvl |=> charging_ff)
    else $error("no charge at valley");
  a_dis_hold: assert property (@(posedge clk) disable iff (rst)
    !charging_ff && rampCnt_ff != DIS_END |=> !charging_ff)
    else $error("discharge cut short");
  a_uv_ext_grow: assert property (@(posedge clk) disable iff (rst)
    uvDis && nxt_state == ACP_UVDIS && cycleStart |=> uvClampExt_ff >= $past(uvClampExt_ff))
    else $error("clamp extension shrank");
endmodule : acp_pwm_seq

// file: rtl/acp_pkg.sv
// Package for the active-clamp PWM sequencer: timing counts, states, widths.
// Assumes a 40 MHz system clock; analog levels arrive as comparator bits.
package acp_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned CLK_PS = 25000;
  // Ramp timing per ohm of timing resistor: charge in hundredths of ps, discharge in ps
  localparam int unsigned ON_PS_PER_OHM_X100 = 3733;
  localparam int unsigned OFF_PS_PER_OHM = 16;
  localparam int unsigned RON_OHM = 50000;
  localparam int unsigned ROFF_OHM = 20000;
  localparam int unsigned CHG_CYC_RAW = (RON_OHM * ON_PS_PER_OHM_X100) / (100 * CLK_PS);
  localparam int unsigned DIS_CYC_RAW = (ROFF_OHM * OFF_PS_PER_OHM) / CLK_PS;
  localparam int unsigned CHG_CYC = (CHG_CYC_RAW < 1) ? 1 : CHG_CYC_RAW;
  localparam int unsigned DIS_CYC = (DIS_CYC_RAW < 1) ? 1 : DIS_CYC_RAW;
  localparam int unsigned CNT_W = 16;
  // Sync pulse minimum width, ns, rounded up to cycles
  localparam int unsigned SYNC_MIN_NS = 50;
  localparam int unsigned SYNC_MIN_CYC = (SYNC_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned SYNC_STUCK_CYC = 4 * (CHG_CYC + DIS_CYC);
  localparam int unsigned SYNC_W = 3;
  localparam int unsigned ZERO_W = 0;

  typedef enum logic [3:0] {
    ACP_OFF = 4'h1,
    ACP_RUN = 4'h2,
    ACP_UVDIS = 4'h4,
    ACP_OVDIS = 4'h8
  } acp_state_e;
endpackage : acp_pkg

// file: rtl/acp_sync_if.sv
// Interface carrying synchronised comparator levels from the input stage.
// Assumes one clock domain; the filter module drives, the core reads.
`timescale 1ns/1ps
interface acp_sync_if;
  logic [7:0] lvl;
  modport src (output lvl);
  modport dst (input lvl);
endinterface : acp_sync_if

// file: rtl/acp_in_sync.sv
// Three-stage synchroniser bank for asynchronous comparator and sync inputs.
// Assumes inputs are raw levels from outside the clk domain.
`timescale 1ns/1ps
module acp_in_sync
  import acp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] rawIn,
  acp_sync_if.src syncOut
);
  logic [7:0] s1_ff;
  logic [7:0] s2_ff;
  logic [7:0] s3_ff;
  logic [7:0] lvl_ff;
  wire logic [7:0] agree = ~(s2_ff ^ s3_ff);
  wire logic [7:0] nxt_lvl = (agree & s3_ff) | (~agree & lvl_ff);

  // First stage feeds only the second; a change counts once stages 2 and 3 agree
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff <= 8'h00;
      s2_ff <= 8'h00;
      s3_ff <= 8'h00;
      lvl_ff <= 8'h00;
    end else begin
      s1_ff <= rawIn;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end
  assign syncOut.lvl = lvl_ff;
endmodule : acp_in_sync

// file: testbench/acp_sync_src.sv
// Sync source model: periodic short high pulses, or a level stuck high.
// Assumes the bench clock; it changes its output at rising edges only.
`timescale 1ns/1ps
module acp_sync_src (
  input wire logic clk,
  input wire logic en,
  input wire logic stuck,
  input wire logic [7:0] period,
  input wire logic [7:0] width,
  output logic syncOut
);
  logic [7:0] cnt_ff = 8'h00;
  always @(posedge clk) begin
    cnt_ff <= (cnt_ff + 8'h1 >= period) ? 8'h0 : cnt_ff + 8'h1;
    // Period under free run; pulse over 50 ns yet well inside the off share
    syncOut <= stuck | (en & (cnt_ff < width));
  end
endmodule : acp_sync_src

// file: testbench/tb.sv
// Bench for the active-clamp PWM sequencer: free run, skip, sync, faults.
// Assumes a 40 MHz clock and the sync source model at the far side.
`timescale 1ns/1ps
module tb import acp_pkg::*; ;
  logic clk, rst, lUv, lOv, refGood, csLimit, fbAboveZero, ssAboveLow, ssAboveCtl;
  logic syncIn, mainGate, clampGate, ssCharge, ssDischarge, rampCharging, sEn, sStuck;
  logic [15:0] hiRun, loRun, lastHi, lastLo, mainRun, mainMax, mainCnt, clampCnt, badCnt;
  logic [15:0] m, c, c2;
  int fails, nChecks;
  acp_pwm_seq acp_pwm_seq_i (.clk(clk), .rst(rst), .lineUnderSense(lUv),
    .lineOverSense(lOv), .refGood(refGood), .csLimit(csLimit), .fbAboveZero(fbAboveZero),
    .ssAboveLow(ssAboveLow), .ssAboveCtl(ssAboveCtl), .syncIn(syncIn), .pwmCmp(16'hffff),
    .clampStep(16'h0004), .mainGate(mainGate), .clampGate(clampGate), .ssCharge(ssCharge),
    .ssDischarge(ssDischarge), .rampCharging(rampCharging));
  acp_sync_src acp_sync_src_i (.clk(clk), .en(sEn), .stuck(sStuck), .period(8'h3c),
    .width(8'h03), .syncOut(syncIn));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Run lengths of the ramp phases and gate activity, kept apart from the core
  always @(posedge clk) begin
    if (rampCharging) begin
      hiRun <= hiRun + 16'h1;
      loRun <= 16'h0;
      if (loRun != 16'h0) lastLo <= loRun;
    end else begin
      loRun <= loRun + 16'h1;
      hiRun <= 16'h0;
      if (hiRun != 16'h0) lastHi <= hiRun;
    end
    mainRun <= mainGate ? mainRun + 16'h1 : 16'h0;
    if (mainRun > mainMax) mainMax <= mainRun;
    mainCnt <= mainCnt + mainGate;
    clampCnt <= clampCnt + clampGate;
    badCnt <= badCnt + (mainGate & clampGate) + (mainGate & ~rampCharging);
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic win(input int n, output logic [15:0] mo, output logic [15:0] co);
    logic [15:0] m0, c0;
    m0 = mainCnt;
    c0 = clampCnt;
    cyc(n);
    mo = mainCnt - m0;
    co = clampCnt - c0;
  endtask : win
  task automatic stop_test;
    $display("checks=%0d fails=%0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic t_free;
    cyc(300);
    chk(lastHi, CHG_CYC[15:0]);
    chk(lastLo, DIS_CYC[15:0]);
    win(172, m, c);
    chk({15'h0, m > 16'h0 && c > 16'h0}, 16'h1);
  endtask : t_free
  task automatic t_skip;
    @(posedge clk) fbAboveZero <= 1'b0;
    cyc(100);
    win(172, m, c);
    chk(m + c, 16'h0);
    @(posedge clk) fbAboveZero <= 1'b1;
    cyc(200);
    @(posedge clk) ssAboveCtl <= 1'b0;
    cyc(100);
    win(172, m, c);
    chk(m + c, 16'h0);
    @(posedge clk) ssAboveCtl <= 1'b1;
    cyc(200);
  endtask : t_skip
  task automatic t_sync;
    @(posedge clk) sEn <= 1'b1;
    cyc(300);
    chk(lastLo, DIS_CYC[15:0]);
    chk(lastHi + lastLo, 16'h003c);
    @(posedge clk) sStuck <= 1'b1;
    cyc(400);
    win(100, m, c);
    chk(m + c, 16'h0);
    @(posedge clk) sStuck <= 1'b0;
    sEn <= 1'b0;
    cyc(300);
  endtask : t_sync
  task automatic t_ov;
    @(posedge clk) lOv <= 1'b1;
    cyc(8);
    win(200, m, c);
    chk(m + c, 16'h0);
    chk({15'h0, ssDischarge}, 16'h1);
    @(posedge clk) lOv <= 1'b0;
    win(200, m, c);
    chk(m + c, 16'h0);
    @(posedge clk) ssAboveLow <= 1'b0;
    cyc(20);
    chk({15'h0, ssCharge}, 16'h1);
    @(posedge clk) ssAboveLow <= 1'b1;
    cyc(300);
    win(172, m, c);
    chk({15'h0, m > 16'h0}, 16'h1);
  endtask : t_ov
  task automatic t_uv;
    @(posedge clk) lUv <= 1'b1;
    cyc(8);
    win(172, m, c);
    chk(m, 16'h0);
    chk({15'h0, c > 16'h0 && ssDischarge}, 16'h1);
    win(172, m, c2);
    chk({15'h0, c2 > c}, 16'h1);
  endtask : t_uv
  initial begin
    {rst, refGood, fbAboveZero, ssAboveLow, ssAboveCtl} = 5'h1f;
    {lUv, lOv, csLimit, sEn, sStuck} = 5'h0;
    {hiRun, loRun, lastHi, lastLo, mainRun, mainMax, mainCnt, clampCnt, badCnt} = '0;
    fails = 0;
    nChecks = 0;
    @(posedge clk);
    @(negedge clk);
    chk({11'h0, mainGate, clampGate, ssCharge, ssDischarge, rampCharging}, 16'h1);
    @(posedge clk) rst <= 1'b0;
    t_free();
    t_skip();
    t_sync();
    t_ov();
    t_uv();
    chk({15'h0, mainMax <= CHG_CYC[15:0]}, 16'h1);
    chk(badCnt, 16'h0);
    stop_test();
  end
  initial begin
    #(25 * 20000);
    fails++;
    stop_test();
  end
endmodule : tb
